// ### mlt_pkg.sv
// package: constants and types for the motion load timer
package mlt_pkg;
    // system clock and timebase
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned TICK_S          = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;
    // short hold, in seconds
    localparam int unsigned SHORT_HOLD_S    = 10;
    // late-window retrigger figures, in seconds
    localparam int unsigned LATE_MIN_DELAY_S = 5 * 60;
    localparam int unsigned LATE_WINDOW_S   = 60;
    // setting sampling period, in seconds
    localparam int unsigned SAMPLE_PERIOD_S = 3;
    // quantiser: 16 raw levels, top two merged into 15
    localparam int unsigned RAW_LEVELS      = 16;
    localparam int unsigned SET_LEVELS      = 15;
    localparam int unsigned LVL_W           = 4;
    localparam int unsigned SEC_W           = 16;
    localparam logic [3:0]  LVL_MAX         = 4'he;
    // reset values
    localparam logic [3:0]  LVL_RST         = 4'h0;
    localparam logic [15:0] SEC_RST         = 16'h0000;

    // relay timing states
    typedef enum logic [1:0] {
        MLT_IDLE,
        MLT_SHORT,
        MLT_FULL
    } mlt_state_t;

    // quantised settings presented to the outside
    typedef struct packed {
        logic [3:0] sens_level;
        logic [3:0] delay_level;
    } mlt_levels_t;
endpackage

// ### mlt_motion_load_timer.sv
// file: relay timing and setting sampling for the motion load timer
`timescale 1ns/1ps

module mlt_motion_load_timer #(
    parameter int unsigned TICK_CYCLES  = mlt_pkg::TICK_CYCLES,
    parameter bit          SHORT_HOLD_EN = 1'b1,
    parameter bit          LATE_MODE_EN  = 1'b1,
    parameter int unsigned ADC_W         = 10,
    // on-time in seconds per delay level, level 0 in the low word
    parameter logic [15*16-1:0] DELAY_TABLE = {
        16'h0708, 16'h0546, 16'h0384, 16'h02d0, 16'h0258,
        16'h01e0, 16'h012c, 16'h00f0, 16'h00b4, 16'h0078,
        16'h003c, 16'h001e, 16'h000f, 16'h000a, 16'h0005}
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_arst_n,
    // detection engine and light comparator
    input  wire logic             i_motion,
    input  wire logic             i_light_ok,
    // setting inputs, already converted
    input  wire logic [ADC_W-1:0] i_sensitivity_setting_input,
    input  wire logic [ADC_W-1:0] i_delay_setting_input,
    // relay drive and status
    output logic                  o_relay_on,
    output logic                  o_short_hold,
    output mlt_pkg::mlt_levels_t  o_levels
);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    mlt_pkg::mlt_state_t state_reg;
    logic [TW-1:0]       tick_cnt_reg;
    logic                tick;
    logic [1:0]          samp_cnt_reg;
    logic                samp_sel_reg;
    logic [15:0]         remain_reg;
    logic [15:0]         full_delay;
    logic                late_active;
    logic                accept;
    logic [3:0]          sens_q;
    logic [3:0]          dly_q;

    // one-second timebase
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_reg <= '0;
        end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end
    assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

    always_comb begin
        sens_q = i_sensitivity_setting_input[ADC_W-1 -: 4];
        dly_q  = i_delay_setting_input[ADC_W-1 -: 4];
        if (sens_q > mlt_pkg::LVL_MAX) begin
            sens_q = mlt_pkg::LVL_MAX;
        end
        if (dly_q > mlt_pkg::LVL_MAX) begin
            dly_q = mlt_pkg::LVL_MAX;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            samp_cnt_reg <= 2'h0;
            samp_sel_reg <= 1'b0;
            o_levels     <= '{sens_level: mlt_pkg::LVL_RST, delay_level: mlt_pkg::LVL_RST};
        end else if (tick) begin
            if (samp_cnt_reg == 2'(mlt_pkg::SAMPLE_PERIOD_S - 1)) begin
                samp_cnt_reg <= 2'h0;
                samp_sel_reg <= ~samp_sel_reg;
                if (samp_sel_reg) begin
                    o_levels.delay_level <= dly_q;
                end else begin
                    o_levels.sens_level <= sens_q;
                end
            end else begin
                samp_cnt_reg <= samp_cnt_reg + 1'b1;
            end
        end
    end

    assign full_delay = DELAY_TABLE[o_levels.delay_level*16 +: 16];

    assign late_active = LATE_MODE_EN
                      && (full_delay >= 16'(mlt_pkg::LATE_MIN_DELAY_S))
                      && (remain_reg > 16'(mlt_pkg::LATE_WINDOW_S));
    // accept motion at once unless late window gates it
    assign accept = i_motion && !late_active;

    // relay state machine
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg  <= mlt_pkg::MLT_IDLE;
            remain_reg <= mlt_pkg::SEC_RST;
        end else begin
            case (state_reg)
                mlt_pkg::MLT_IDLE: begin
                    if (i_motion && i_light_ok) begin
                        // short hold capped at 10 s
                        if (SHORT_HOLD_EN
                            && full_delay > 16'(mlt_pkg::SHORT_HOLD_S)) begin
                            state_reg  <= mlt_pkg::MLT_SHORT;
                            remain_reg <= 16'(mlt_pkg::SHORT_HOLD_S);
                        end else begin
                            state_reg  <= mlt_pkg::MLT_FULL;
                            remain_reg <= full_delay;
                        end
                    end
                end
                mlt_pkg::MLT_SHORT: begin
                    if (i_motion) begin
                        state_reg  <= mlt_pkg::MLT_FULL;
                        remain_reg <= full_delay;
                    end else if (tick) begin
                        if (remain_reg <= 16'h0001) begin
                            state_reg  <= mlt_pkg::MLT_IDLE;
                            remain_reg <= 16'h0000;
                        end else begin
                            remain_reg <= remain_reg - 1'b1;
                        end
                    end
                end
                mlt_pkg::MLT_FULL: begin
                    if (accept) begin
                        remain_reg <= full_delay;
                    end else if (tick) begin
                        if (remain_reg <= 16'h0001) begin
                            state_reg  <= mlt_pkg::MLT_IDLE;
                            remain_reg <= 16'h0000;
                        end else begin
                            remain_reg <= remain_reg - 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg  <= mlt_pkg::MLT_IDLE;
                    remain_reg <= 16'h0000;
                end
            endcase
        end
    end

    // registered relay outputs, follow state one cycle later
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_relay_on   <= 1'b0;
            o_short_hold <= 1'b0;
        end else begin
            o_relay_on   <= (state_reg != mlt_pkg::MLT_IDLE);
            o_short_hold <= (state_reg == mlt_pkg::MLT_SHORT);
        end
    end
endmodule

// ### mlt_props.sv
// checker: relay timing and level properties
`timescale 1ns/1ps
module mlt_props #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic                 i_sys_clk,
    input wire logic                 i_arst_n,
    input wire logic                 i_motion,
    input wire logic                 i_light_ok,
    input wire logic                 o_relay_on,
    input wire logic                 o_short_hold,
    input wire mlt_pkg::mlt_levels_t o_levels
);
    logic [15:0] hold_cnt_reg;
    // cycles spent in the short hold
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) hold_cnt_reg <= 16'h0000;
        else hold_cnt_reg <= o_short_hold ? hold_cnt_reg + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_turn_on;
        $rose(o_relay_on);
    endsequence
    chk_hold_bound: assert property (hold_cnt_reg <= 11 * TICK_CYCLES)
        else $error("short hold too long");
    chk_hold_in_on: assert property (o_short_hold |-> o_relay_on)
        else $error("short hold without relay");
    chk_needs_light: assert property (s_turn_on |-> $past(i_light_ok, 2) && $past(i_motion, 2))
        else $error("relay rose without lit motion");
    chk_short_first: assert property (s_turn_on ##0 (o_levels.delay_level > 4'h1) |-> o_short_hold)
        else $error("first trigger skipped short hold");
    chk_short_from_off: assert property ($rose(o_short_hold) |-> $rose(o_relay_on))
        else $error("short hold entered while relay held");
    chk_min_hold: assert property (s_turn_on |-> o_relay_on [*8])
        else $error("relay dropped early");
    chk_level_clamp: assert property (o_levels.sens_level != 4'hf && o_levels.delay_level != 4'hf)
        else $error("level above fourteen");
    chk_alt_sample: assert property (!($changed(o_levels.sens_level) && $changed(o_levels.delay_level)))
        else $error("both levels changed together");
endmodule

// ### mlt_pir_model.sv
// model: detection engine events and light comparator
`timescale 1ns/1ps
module mlt_pir_model (
    // bench requests
    input  wire logic i_sys_clk,
    input  wire logic i_fire,
    input  wire logic i_bright,
    // lines into the timer
    output logic      o_motion,
    output logic      o_light_ok
);
    // one event per request cycle, light level alongside
    always_ff @(posedge i_sys_clk) begin
        o_motion   <= i_fire;
        o_light_ok <= i_bright;
    end
endmodule

// ### mlt_motion_load_timer_tb.sv
// testbench: scenarios for the motion load timer
`timescale 1ns/1ps
module mlt_motion_load_timer_tb;
    localparam int unsigned TK = 10;
    logic                 i_sys_clk = 1'b0;
    logic                 i_arst_n  = 1'b0;
    logic                 fire      = 1'b0;
    logic                 bright    = 1'b0;
    logic                 motion;
    logic                 light_ok;
    logic                 relay_on;
    logic                 short_hold;
    logic [9:0]           sens_in   = 10'h3ff;
    logic [9:0]           dly_in    = 10'h0c0;
    mlt_pkg::mlt_levels_t levels;
    int                   mismatches = 0;
    int                   check_count = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    mlt_pir_model i_mlt_pir_model (.i_sys_clk(i_sys_clk), .i_fire(fire), .i_bright(bright),
        .o_motion(motion), .o_light_ok(light_ok));
    mlt_motion_load_timer #(.TICK_CYCLES(TK)) i_mlt_motion_load_timer (.i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n), .i_motion(motion), .i_light_ok(light_ok),
        .i_sensitivity_setting_input(sens_in), .i_delay_setting_input(dly_in),
        .o_relay_on(relay_on), .o_short_hold(short_hold), .o_levels(levels));
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic fire_event(input logic b);
        @(posedge i_sys_clk);
        fire   <= 1'b1;
        bright <= b;
        @(posedge i_sys_clk);
        fire   <= 1'b0;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_lvl(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // dark start, short hold expiry, then extension to full delay
    task automatic t_short();
        fire_event(1'b0);
        step(4);
        cmp_bit(relay_on, 1'b0);
        fire_event(1'b1);
        step(4);
        cmp_bit(short_hold, 1'b1);
        step(11 * TK);
        cmp_bit(relay_on, 1'b0);
        fire_event(1'b1);
        step(4 * TK);
        fire_event(1'b0);
        step(4);
        cmp_bit(short_hold, 1'b0);
        cmp_bit(relay_on, 1'b1);
        step(31 * TK);
        cmp_bit(relay_on, 1'b0);
    endtask
    // retrigger ignored or accepted by delay level
    task automatic t_late(input logic [9:0] d, input int gap, input int wait_s, input logic exp);
        @(posedge i_sys_clk);
        dly_in <= d;
        step(7 * TK);
        fire_event(1'b1);
        step(2 * TK);
        fire_event(1'b1);
        step(gap * TK);
        fire_event(1'b1);
        step(wait_s * TK);
        cmp_bit(relay_on, exp);
    endtask
    initial begin
        #(25 * 800 * TK);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        step(7 * TK);
        cmp_lvl(levels.sens_level, 4'he);
        cmp_lvl(levels.delay_level, 4'h3);
        t_short();
        t_late(10'h200, 100, 205, 1'b0);
        t_late(10'h0c0, 20, 25, 1'b1);
        report_and_stop();
    end
endmodule
bind mlt_motion_load_timer mlt_props #(.TICK_CYCLES(TICK_CYCLES)) i_mlt_props (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_motion(i_motion), .i_light_ok(i_light_ok),
    .o_relay_on(o_relay_on), .o_short_hold(o_short_hold), .o_levels(o_levels));
